/* File: rtl/etc_pkg.sv */
package etc_pkg;

  localparam int unsigned MATCH_UNITS = 8;
  localparam int unsigned SEQ_MAX     = 16;
  localparam int unsigned SEQ_LEVELS  = 8;
  localparam int unsigned LVL_W       = 4;
  localparam int unsigned MU_W        = 3;
  localparam int unsigned DEPTH       = 256;
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned SAMPLE_W    = 32;

  // Delay from trigger event to trigger output
  localparam int unsigned OUT_DELAY_CYC = 10;
  localparam logic [3:0]  OUT_DLY_LAST  = 4'(OUT_DELAY_CYC - 1);

  // APB register byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_BOOL    = 8'h04;
  localparam logic [7:0] REG_SEQCFG  = 8'h08;
  localparam logic [7:0] REG_SEQMU   = 8'h0C;
  localparam logic [7:0] REG_STATUS  = 8'h10;
  localparam logic [7:0] REG_RDPTR   = 8'h14;
  localparam logic [7:0] REG_RDDATA  = 8'h18;

  // CTRL command bits (self clearing)
  localparam int unsigned CMD_RUN   = 0;
  localparam int unsigned CMD_STOP  = 1;
  localparam int unsigned CMD_FORCE = 2;

  // BOOL field positions
  localparam int unsigned BOOL_EN_LSB  = 0;
  localparam int unsigned BOOL_INV_LSB = 8;
  localparam int unsigned BOOL_OR_BIT  = 16;
  localparam int unsigned BOOL_NEG_BIT = 17;
  localparam int unsigned BOOL_SEQ_BIT = 18;
  localparam int unsigned BOOL_SET_BIT = 19;
  localparam int unsigned OUTM_LSB     = 20;

  // SEQCFG field positions
  localparam int unsigned SEQ_NUM_LSB  = 0;
  localparam int unsigned SEQ_CONT_BIT = 4;
  localparam int unsigned SEQ_NEG_LSB  = 8;

  // Reset/startup configuration values
  localparam logic [MATCH_UNITS-1:0] RST_EN  = '1;
  localparam logic [MATCH_UNITS-1:0] RST_INV = '0;

  typedef enum logic [2:0] {
    ETC_OUT_OFF    = 3'h0,
    ETC_OUT_PULSEH = 3'h1,
    ETC_OUT_PULSEL = 3'h2,
    ETC_OUT_LEVELH = 3'h3,
    ETC_OUT_LEVELL = 3'h4
  } etc_outmode_e;

  typedef enum logic [1:0] {
    ETC_IDLE = 2'b00,
    ETC_ARM  = 2'b01,
    ETC_CAP  = 2'b11,
    ETC_FULL = 2'b10
  } etc_state_e;

  typedef struct packed {
    logic [MATCH_UNITS-1:0] en;
    logic [MATCH_UNITS-1:0] inv;
    logic                   use_or;
    logic                   negate;
    logic                   use_seq;
    logic                   setup_done;
  } etc_bool_s;

  typedef struct packed {
    logic [LVL_W-1:0]      levels;
    logic                  contiguous;
    logic [SEQ_LEVELS-1:0] neg;
  } etc_seq_s;

endpackage : etc_pkg

/* File: rtl/etc_trigger_unit.sv */
// Operation
// - One selected trigger condition evaluated at once
// - Default condition is AND of all units
// - Per-unit enable and invert in Boolean mode
// - Enabled events combined by AND or OR
// - Whole Boolean equation can be inverted
// - Sequencer advances one level per match
// - Level count built-in, max 8, runtime selectable
// - Per-level invert of match unit sense
// - Default sequence allows gaps between matches
// - Contiguous option: gap resets the sequence
// - Disabled trigger output held low
// - Pulse high one cycle, ten after trigger
// - Pulse low one cycle, ten after trigger
// - Level high from ten cycles after trigger
// - Level low from ten cycles after trigger
// - Armed until trigger or disarm
// - Capture after trigger, stop when full
// - Force trigger bypasses conditions, sample zero
// - Stop disarms and discards; run rearms from idle or full
// - Startup settings built into configuration
// - Startup trigger arms once after startup
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module etc_trigger_unit
  import etc_pkg::*;
#(
  parameter logic                    STARTUP_ARM = 1'b0,
  parameter logic [2:0]              STARTUP_OUT = 3'h0
) (
  // Clock, reset, enable
  input  wire logic                           ref_clk,
  input  wire logic                           reset_n,
  input  wire logic                           clk_en,
  // Device still in startup state
  input  wire logic                           in_startup,
  // Match unit events and probe data, same clock
  input  wire logic [etc_pkg::MATCH_UNITS-1:0] match_evt,
  input  wire logic [etc_pkg::SAMPLE_W-1:0]    probe_data,
  // APB slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [7:0]                     paddr,
  input  wire logic [31:0]                    pwdata,
  output logic [31:0]                         prdata,
  output logic                                pready,
  output logic                                pslverr,
  // Trigger output
  output logic                                trig_out
);
  import etc_pkg::*;

  etc_bool_s          bool_q;
  etc_seq_s           seq_q;
  logic [MU_W-1:0]    seq_mu_q [SEQ_LEVELS];
  etc_outmode_e       outm_q;
  etc_state_e         state_q;
  logic [LVL_W-1:0]   level_q;
  logic [ADDR_W:0]    wr_cnt_q;
  logic [ADDR_W-1:0]  rd_ptr_q;
  logic [SAMPLE_W-1:0] buf_mem [DEPTH];
  logic [SAMPLE_W-1:0] rd_data_q;
  logic [3:0]         dly_cnt_q;
  logic               dly_run_q;
  logic               fired_q;
  logic               pulse_q;
  logic               startup_done_q;
  logic               startup_q1;
  logic               startup_q2;

  logic wr_acc;
  logic rd_acc;
  logic cmd_run;
  logic cmd_stop;
  logic cmd_force;
  logic bool_hit;
  logic lvl_hit;
  logic seq_done;
  logic trig_hit;
  logic start_arm;
  logic full_now;

  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_acc  = psel && penable && pwrite && clk_en;
  assign rd_acc  = psel && penable && !pwrite && clk_en;
  assign cmd_run   = wr_acc && (paddr == REG_CTRL) && pwdata[CMD_RUN];
  assign cmd_stop  = wr_acc && (paddr == REG_CTRL) && pwdata[CMD_STOP];
  assign cmd_force = wr_acc && (paddr == REG_CTRL) && pwdata[CMD_FORCE];

  function automatic logic lvl_match(input logic [MATCH_UNITS-1:0] ev,
                                     input logic [MU_W-1:0] mu, input logic neg);
    lvl_match = ev[mu] ^ neg;
  endfunction : lvl_match

  // Startup state crosses in from configuration logic
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      startup_q1 <= 1'b1;
      startup_q2 <= 1'b1;
    end else if (clk_en) begin
      startup_q1 <= in_startup;
      startup_q2 <= startup_q1;
    end
  end

  // Boolean combination with unit enables and inverts
  always_comb begin
    logic [MATCH_UNITS-1:0] ev;
    ev = match_evt ^ bool_q.inv;
    if (bool_q.use_or) begin
      bool_hit = |(ev & bool_q.en);
    end else begin
      bool_hit = &(ev | ~bool_q.en);
    end
    bool_hit = bool_hit ^ bool_q.negate;
  end

  assign lvl_hit  = lvl_match(match_evt, seq_mu_q[level_q[2:0]],
                              seq_q.neg[level_q[2:0]]);
  assign seq_done = lvl_hit && (level_q == seq_q.levels);
  // Only the selected condition reaches the arm logic
  assign trig_hit = bool_q.use_seq ? seq_done : bool_hit;
  assign full_now = wr_cnt_q[ADDR_W];
  assign start_arm = STARTUP_ARM && !startup_done_q && !startup_q2;

  // Sequencer level counter
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      level_q <= '0;
    end else if (clk_en) begin
      if (state_q != ETC_ARM || seq_done) begin
        level_q <= '0;
      end else if (lvl_hit) begin
        level_q <= level_q + LVL_W'(1);
      end else if (seq_q.contiguous) begin
        level_q <= '0;
      end
    end
  end

  // Arm, capture and full control
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q        <= ETC_IDLE;
      startup_done_q <= 1'b0;
    end else if (clk_en) begin
      if (start_arm) begin
        startup_done_q <= 1'b1;
      end
      if (cmd_stop) begin
        state_q <= ETC_IDLE;
      end else if (cmd_force && state_q != ETC_CAP) begin
        state_q <= ETC_CAP;
      end else begin
        unique case (state_q)
          ETC_IDLE, ETC_FULL: begin
            if (cmd_run || start_arm) begin
              state_q <= ETC_ARM;
            end
          end
          ETC_ARM: begin
            if (trig_hit) begin
              state_q <= ETC_CAP;
            end
          end
          ETC_CAP: begin
            if (wr_cnt_q == (ADDR_W + 1)'(DEPTH - 1)) begin
              state_q <= ETC_FULL;
            end
          end
        endcase
      end
    end
  end

  // Sample buffer write counter; sample 0 is the cycle after the trigger
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_cnt_q <= '0;
    end else if (clk_en) begin
      if (cmd_stop || cmd_run || (state_q == ETC_ARM && trig_hit) ||
          (cmd_force && state_q != ETC_CAP)) begin
        wr_cnt_q <= '0;
      end else if (state_q == ETC_CAP && !full_now) begin
        wr_cnt_q <= wr_cnt_q + (ADDR_W + 1)'(1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clk_en && state_q == ETC_CAP && !full_now) begin
      buf_mem[wr_cnt_q[ADDR_W-1:0]] <= probe_data;
    end
  end

  // Configuration registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bool_q     <= '{en: RST_EN, inv: RST_INV, use_or: 1'b0,
                      negate: 1'b0, use_seq: 1'b0, setup_done: 1'b0};
      seq_q      <= '{levels: '0, contiguous: 1'b0, neg: '0};
      outm_q     <= etc_outmode_e'(STARTUP_OUT);
      rd_ptr_q   <= '0;
      for (int i = 0; i < SEQ_LEVELS; i++) begin
        seq_mu_q[i] <= '0;
      end
    end else if (clk_en) begin
      if (wr_acc) begin
        unique case (paddr)
          REG_BOOL: begin
            bool_q.en      <= pwdata[BOOL_EN_LSB +: MATCH_UNITS];
            bool_q.inv     <= pwdata[BOOL_INV_LSB +: MATCH_UNITS];
            bool_q.use_or  <= pwdata[BOOL_OR_BIT];
            bool_q.negate  <= pwdata[BOOL_NEG_BIT];
            bool_q.use_seq <= pwdata[BOOL_SEQ_BIT];
            bool_q.setup_done <= pwdata[BOOL_SET_BIT];
            outm_q <= etc_outmode_e'(pwdata[OUTM_LSB +: 3]);
          end
          REG_SEQCFG: begin
            // Levels above build size clamp to the last level
            seq_q.levels <= (pwdata[SEQ_NUM_LSB +: LVL_W] > LVL_W'(SEQ_LEVELS - 1)) ?
                            LVL_W'(SEQ_LEVELS - 1) : pwdata[SEQ_NUM_LSB +: LVL_W];
            seq_q.contiguous <= pwdata[SEQ_CONT_BIT];
            seq_q.neg        <= pwdata[SEQ_NEG_LSB +: SEQ_LEVELS];
          end
          REG_SEQMU: begin
            for (int i = 0; i < SEQ_LEVELS; i++) begin
              seq_mu_q[i] <= pwdata[i*MU_W +: MU_W];
            end
          end
          REG_RDPTR: rd_ptr_q <= pwdata[ADDR_W-1:0];
          default: ;
        endcase
      end else if (rd_acc && paddr == REG_RDDATA) begin
        rd_ptr_q <= rd_ptr_q + ADDR_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      rd_data_q <= buf_mem[rd_ptr_q];
    end
  end

  // Read mux
  always_comb begin
    prdata = '0;
    if (psel && !pwrite) begin
      unique case (paddr)
        REG_BOOL:   prdata = {9'h000, 3'(outm_q), bool_q.setup_done, bool_q.use_seq,
                              bool_q.negate, bool_q.use_or, bool_q.inv, bool_q.en};
        REG_SEQCFG: prdata = {16'h0000, seq_q.neg, 3'h0, seq_q.contiguous, seq_q.levels};
        REG_STATUS: prdata = {16'h0000, level_q, fired_q, 2'(state_q),
                              wr_cnt_q};
        REG_RDPTR:  prdata = {24'h000000, rd_ptr_q};
        REG_RDDATA: prdata = rd_data_q;
        default:    prdata = '0;
      endcase
    end
  end

  // Trigger output delay line
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dly_cnt_q <= '0;
      dly_run_q <= 1'b0;
      fired_q   <= 1'b0;
      pulse_q   <= 1'b0;
    end else if (clk_en) begin
      pulse_q <= 1'b0;
      if (cmd_run || cmd_stop) begin
        fired_q   <= 1'b0;
        dly_run_q <= 1'b0;
      end else if (state_q == ETC_ARM && trig_hit) begin
        dly_run_q <= 1'b1;
        dly_cnt_q <= '0;
      end else if (dly_run_q) begin
        if (dly_cnt_q == OUT_DLY_LAST - 4'h1) begin
          dly_run_q <= 1'b0;
          fired_q   <= 1'b1;
          pulse_q   <= 1'b1;
        end
        dly_cnt_q <= dly_cnt_q + 4'h1;
      end
    end
  end

  always_comb begin
    unique case (outm_q)
      ETC_OUT_PULSEH: trig_out = pulse_q;
      ETC_OUT_PULSEL: trig_out = !pulse_q;
      ETC_OUT_LEVELH: trig_out = fired_q;
      ETC_OUT_LEVELL: trig_out = !fired_q;
      default:        trig_out = 1'b0;
    endcase
  end

  // Checks
  chk_pulse_delay: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (clk_en && state_q == ETC_ARM && trig_hit && !cmd_stop && !cmd_run &&
     !cmd_force) ##1 (clk_en && !cmd_run && !cmd_stop) [*5]
    ##1 (clk_en && !cmd_run && !cmd_stop) [*5] |-> pulse_q)
    else $error("trigger pulse not ten cycles after trigger");
  chk_out_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
    outm_q == ETC_OUT_OFF |-> !trig_out)
    else $error("disabled trigger output not low");
  chk_arm_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (clk_en && state_q == ETC_ARM && !trig_hit && !cmd_stop && !cmd_force) |=>
     state_q == ETC_ARM)
    else $error("left armed state without cause");
  chk_stop_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (clk_en && cmd_stop) |=> (state_q == ETC_IDLE && wr_cnt_q == '0))
    else $error("stop did not disarm and discard");
  chk_full_stop: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_q == ETC_FULL) |-> full_now)
    else $error("full state without full buffer");
  chk_force_cap: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (clk_en && cmd_force && !cmd_stop && state_q != ETC_CAP) |=>
     (state_q == ETC_CAP && wr_cnt_q == '0))
    else $error("force did not start capture at sample zero");
  chk_contig_gap: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (clk_en && seq_q.contiguous && state_q == ETC_ARM && !lvl_hit) |=> level_q == '0)
    else $error("contiguous sequence survived a gap");
  chk_level_cap: assert property (@(posedge ref_clk) disable iff (!reset_n)
    seq_q.levels < LVL_W'(SEQ_LEVELS))
    else $error("sequence level count above build size");
  chk_pulse_single: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (clk_en && pulse_q) |=> !pulse_q)
    else $error("trigger pulse longer than one cycle");
  chk_level_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (clk_en && fired_q && !cmd_run && !cmd_stop) |=> fired_q)
    else $error("trigger level dropped without rearm");
  cov_trigger:  cover property (@(posedge ref_clk) state_q == ETC_ARM ##1 state_q == ETC_CAP);
  cov_full:     cover property (@(posedge ref_clk) state_q == ETC_FULL);
  cov_seq_done: cover property (@(posedge ref_clk) bool_q.use_seq && seq_done);
  cov_force:    cover property (@(posedge ref_clk) state_q == ETC_IDLE ##1 state_q == ETC_CAP);
  cov_contig:   cover property (@(posedge ref_clk) seq_q.contiguous && bool_q.use_seq && seq_done);

endmodule : etc_trigger_unit
`default_nettype wire

/* File: tb/etc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module etc_host_model (
  // Clock
  input  wire logic        ref_clk,
  // APB master side
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready
);
  import etc_pkg::*;

  int fails;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    fails = 0;
  end

  // One APB transfer, held until pready is seen high
  task automatic xfer(input logic dir, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd_data);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= dir;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) fails++;
    rd_data = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    xfer(1'b0, a, 32'h0000_0000, d);
  endtask : rd

  task automatic wait_full(output logic [31:0] s);
    int n;
    n = 0;
    do begin
      rd(REG_STATUS, s);
      n++;
    end while (s[10:9] !== 2'b10 && n < 300);
    if (s[10:9] !== 2'b10) fails++;
  endtask : wait_full

  // Run or force, wait for a full buffer, upload two words, stop
  task automatic run_once(input logic [31:0] cmd, output logic [31:0] w0,
                          output logic [31:0] w1);
    logic [31:0] s;
    wr(REG_CTRL, cmd);
    wait_full(s);
    wr(REG_RDPTR, 32'h0000_0000);
    @(posedge ref_clk);
    rd(REG_RDDATA, w0);
    rd(REG_RDDATA, w1);
    wr(REG_CTRL, 32'h0000_0002);
  endtask : run_once

endmodule : etc_host_model
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import etc_pkg::*;

  logic                   ref_clk;
  logic                   reset_n;
  logic                   clk_en;
  logic                   in_startup;
  logic [MATCH_UNITS-1:0] match_evt;
  logic [SAMPLE_W-1:0]    probe_data;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [7:0]             paddr;
  logic [31:0]            pwdata;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   trig_out;
  logic                   su_trig;
  logic                   su_psel;
  logic                   idle;
  logic [31:0]            s;
  logic [31:0]            w0;
  logic [31:0]            w1;
  int                     errors;
  int                     comparisons;
  int                     n;
  int                     k;

  etc_trigger_unit i_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .in_startup(in_startup),
    .match_evt(match_evt), .probe_data(probe_data), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trig_out(trig_out));

  etc_trigger_unit #(.STARTUP_ARM(1'b1), .STARTUP_OUT(3'h3)) i_dut_su (
    .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .in_startup(in_startup),
    .match_evt(match_evt), .probe_data(probe_data), .psel(su_psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
    .pready(), .pslverr(), .trig_out(su_trig));

  etc_host_model i_host (
    .ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Probe data counts so that uploaded samples can be ordered
  always @(posedge ref_clk) begin
    if (reset_n !== 1'b1) begin
      probe_data <= '0;
    end else begin
      probe_data <= probe_data + 32'h1;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic print_verdict();
    errors += i_host.fails;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  task automatic do_reset();
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
  endtask : do_reset

  task automatic evt(input logic [MATCH_UNITS-1:0] v);
    @(posedge ref_clk);
    match_evt <= v;
  endtask : evt

  // Drive events, let them settle, compare the unit state
  task automatic expect_st(input logic [MATCH_UNITS-1:0] v, input logic [1:0] st);
    logic [31:0] r;
    evt(v);
    repeat (3) @(posedge ref_clk);
    i_host.rd(REG_STATUS, r);
    check(32'(r[10:9]), 32'(st));
  endtask : expect_st

  initial begin
    #900000;
    errors++;
    print_verdict();
  end

  initial begin
    errors = 0;
    comparisons = 0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    in_startup = 1'b1;
    match_evt = '0;
    su_psel = 1'b0;
    for (int m = 0; m < 5; m++) begin
      do_reset();
      evt(8'h00);
      i_host.wr(REG_BOOL, {9'h000, 3'(m), 20'h000FF});
      i_host.wr(REG_CTRL, 32'h1);
      idle = (m == 2 || m == 4);
      check(32'(trig_out), 32'(idle));
      evt(8'hFF);
      n = 0;
      k = 0;
      for (int i = 1; i <= 15; i++) begin
        @(posedge ref_clk);
        #1;
        if (trig_out !== idle) k++;
        if (n == 0 && trig_out !== idle) n = i;
      end
      check(n, (m == 0) ? 0 : 10);
      check(k, (m == 0) ? 0 : (m <= 2) ? 1 : 6);
    end
    $display("test output modes done");
    do_reset();
    evt(8'h00);
    i_host.rd(8'h1C, s);
    check(s, 32'h0);
    check(32'(pslverr), 32'h0);
    i_host.wr(REG_CTRL, 32'h1);
    expect_st(8'h7F, 2'b01);
    expect_st(8'hFF, 2'b11);
    evt(8'h00);
    i_host.wait_full(s);
    check(32'(s[10:0]), 32'h500);
    repeat (20) @(posedge ref_clk);
    i_host.rd(REG_STATUS, s);
    check(32'(s[10:0]), 32'h500);
    $display("test default condition done");
    i_host.wr(REG_BOOL, 32'h0001_0103);
    evt(8'h81);
    i_host.wr(REG_CTRL, 32'h1);
    expect_st(8'h81, 2'b01);
    expect_st(8'h83, 2'b11);
    i_host.wr(REG_CTRL, 32'h2);
    i_host.rd(REG_STATUS, s);
    check(32'(s[10:0]), 32'h0);
    i_host.wr(REG_BOOL, 32'h0003_0103);
    i_host.wr(REG_CTRL, 32'h1);
    expect_st(8'h83, 2'b01);
    expect_st(8'h81, 2'b11);
    i_host.wr(REG_CTRL, 32'h2);
    $display("test boolean done");
    i_host.wr(REG_SEQMU, 32'h0000_00C8);
    i_host.wr(REG_SEQCFG, 32'h0000_0102);
    i_host.wr(REG_BOOL, 32'h0004_00FF);
    i_host.wr(REG_CTRL, 32'h1);
    expect_st(8'hFF, 2'b01);
    expect_st(8'h00, 2'b01);
    expect_st(8'h02, 2'b01);
    expect_st(8'h00, 2'b01);
    expect_st(8'h08, 2'b11);
    i_host.wr(REG_CTRL, 32'h2);
    i_host.wr(REG_SEQCFG, 32'h0000_0012);
    i_host.wr(REG_CTRL, 32'h1);
    evt(8'h01);
    evt(8'h00);
    evt(8'h02);
    evt(8'h08);
    expect_st(8'h00, 2'b01);
    evt(8'h01);
    evt(8'h02);
    expect_st(8'h08, 2'b11);
    i_host.wr(REG_CTRL, 32'h2);
    $display("test sequencer done");
    i_host.wr(REG_BOOL, 32'h0000_00FF);
    evt(8'h00);
    i_host.run_once(32'h4, w0, w1);
    check(w1 - w0, 32'h1);
    evt(8'hFF);
    i_host.run_once(32'h1, w0, w1);
    check(w1 - w0, 32'h1);
    $display("test force and upload done");
    repeat (20) @(posedge ref_clk);
    check(32'(su_trig), 32'h0);
    @(posedge ref_clk);
    in_startup <= 1'b0;
    n = 0;
    for (int i = 1; i <= 40; i++) begin
      @(posedge ref_clk);
      #1;
      if (n == 0 && su_trig === 1'b1) n = i;
    end
    check(n, 13);
    $display("test startup done");
    print_verdict();
  end

endmodule : testbench
`default_nettype wire
